// file: hdl/ptp_time_counter_regs.sv
// ptp_time_counter_regs: register set and time counter for precision time
// stamping; nanoseconds and seconds advance by a fractional increment.
// assumes: one clock, the register port master never issues read and write
// in the same cycle, and read data is taken in the cycle after the strobe.
//
// Contract
// - registers exist only with bridging option built
// - nanosecond offset is 30 bits, top reserved
// - seconds offset split 32 low, 16 high
// - nanosecond offset write loads all offsets together
// - counter advances by 26-bit increment each cycle
// - increment unit is 2^-20 nanosecond
// - nanoseconds read returns latest count
// - nanoseconds read captures seconds for later reads
// - sampled seconds readable as low and high words
// - periodic timer interrupt held until cleared
// - any write to clear bit drops interrupt; a clear write in a seconds-rollover cycle leaves it set
// - phase offset added before deriving timing output
// - derived output is phase-shiftable 8 kHz wave
// - phase shift resolution is one nanosecond
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module ptp_time_counter_regs
  import ptp_time_pkg::*;
#(
  parameter bit audio_video_bridging_option = 1'b1
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic timer_irq_o,
  output logic eight_khz_timing_out_o
);

  // ==========================================================================
  // decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // zero-extends a field into a bus word
  function automatic logic [DATA_W-1:0] widen_ns(input logic [NS_W-1:0] v);
    widen_ns = {{(DATA_W-NS_W){1'b0}}, v};
  endfunction

  // ==========================================================================
  // declarations
  localparam logic opt_en = audio_video_bridging_option;

  logic [NS_W-1:0] ns_off_r;
  logic [SEC_LO_W-1:0] sec_off_lo_r;
  logic [SEC_HI_W-1:0] sec_off_hi_r;
  logic [INC_W-1:0] inc_r;
  logic [PHASE_W-1:0] phase_r;
  logic [NS_W-1:0] ns_r;
  logic [FRAC_W-1:0] frac_r;
  logic [SEC_W-1:0] sec_r;
  logic [SEC_W-1:0] sec_snap_r;
  logic [DATA_W-1:0] rdata_r;
  logic irq_r;

  logic wr_ns_off;
  logic wr_sec_lo;
  logic wr_sec_hi;
  logic wr_inc;
  logic wr_phase;
  logic wr_irq_clr;
  logic rd_cur_ns;
  logic [ACC_W-1:0] acc_nxt;
  logic [NS_W-1:0] ns_sum;
  logic sec_carry;
  logic [NS_W-1:0] ns_nxt;
  logic [FRAC_W-1:0] frac_nxt;
  logic [SEC_W-1:0] sec_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  // ==========================================================================
  // strobe decode, all gated by the build option
  always_comb begin
    wr_ns_off = opt_en && wr_i && hit(addr_i, NANOSECOND_STEP_OFFSET);
    wr_sec_lo = opt_en && wr_i && hit(addr_i, SECOND_STEP_OFFSET_LOW);
    wr_sec_hi = opt_en && wr_i && hit(addr_i, SECOND_STEP_OFFSET_HIGH);
    wr_inc = opt_en && wr_i && hit(addr_i, COUNT_INCREMENT);
    wr_phase = opt_en && wr_i && hit(addr_i, OUTPUT_PHASE_OFFSET);
    wr_irq_clr = opt_en && wr_i && hit(addr_i, TIMER_IRQ_CLEAR);
    rd_cur_ns = opt_en && rd_i && hit(addr_i, CURRENT_NANOSECONDS);
  end

  // ==========================================================================
  // offset registers
  // seconds halves are staged only; they reach the counter with the
  // nanoseconds write so a step never shows a half-updated time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ns_off_r <= NS_RST;
      sec_off_lo_r <= SEC_RST[SEC_LO_W-1:0];
      sec_off_hi_r <= SEC_RST[SEC_W-1:SEC_LO_W];
    end else begin
      if (wr_ns_off) begin
        ns_off_r <= wdata_i[NS_W-1:0];
      end
      if (wr_sec_lo) begin
        sec_off_lo_r <= wdata_i[SEC_LO_W-1:0];
      end
      if (wr_sec_hi) begin
        sec_off_hi_r <= wdata_i[SEC_HI_W-1:0];
      end
    end
  end

  // increment and phase registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      inc_r <= INC_RST;
      phase_r <= PHASE_RST;
    end else begin
      if (wr_inc) begin
        inc_r <= wdata_i[INC_W-1:0];
      end
      if (wr_phase) begin
        phase_r <= wdata_i[PHASE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // time counter
  // the increment carries 20 fraction bits below the nanoseconds field;
  // at most 64 ns per cycle, so one subtraction always brings it in range
  always_comb begin
    acc_nxt = {ns_r, frac_r} + {{(ACC_W-INC_W){1'b0}}, inc_r};
    ns_sum = acc_nxt[ACC_W-1:FRAC_W];
    sec_carry = (ns_sum >= NS_PER_SEC);
    frac_nxt = acc_nxt[FRAC_W-1:0];
    ns_nxt = sec_carry ? (ns_sum - NS_PER_SEC) : ns_sum;
    sec_nxt = sec_carry ? (sec_r + SEC_ONE) : sec_r;
  end

  // count update; an offset step replaces the count in one cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ns_r <= NS_RST;
      frac_r <= FRAC_RST;
      sec_r <= SEC_RST;
    end else if (wr_ns_off) begin
      ns_r <= wdata_i[NS_W-1:0];
      frac_r <= FRAC_RST;
      sec_r <= {sec_off_hi_r, sec_off_lo_r};
    end else if (opt_en) begin
      ns_r <= ns_nxt;
      frac_r <= frac_nxt;
      sec_r <= sec_nxt;
    end
  end

  // ==========================================================================
  // seconds snapshot, taken with every current-nanoseconds read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sec_snap_r <= SEC_RST;
    end else if (rd_cur_ns) begin
      sec_snap_r <= sec_r;
    end
  end

  // ==========================================================================
  // periodic timer interrupt: set on each seconds rollover, set beats clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else if (opt_en && !wr_ns_off && sec_carry) begin
      irq_r <= 1'b1;
    end else if (wr_irq_clr) begin
      irq_r <= 1'b0;
    end
  end

  // interrupt level straight from its flop
  assign timer_irq_o = irq_r;

  // ==========================================================================
  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_nxt = READ_ZERO;
    if (opt_en && rd_i) begin
      unique case (addr_i)
        NANOSECOND_STEP_OFFSET: rdata_nxt = widen_ns(ns_off_r);
        SECOND_STEP_OFFSET_LOW: rdata_nxt = sec_off_lo_r;
        SECOND_STEP_OFFSET_HIGH: rdata_nxt = {{(DATA_W-SEC_HI_W){1'b0}}, sec_off_hi_r};
        COUNT_INCREMENT: rdata_nxt = {{(DATA_W-INC_W){1'b0}}, inc_r};
        CURRENT_NANOSECONDS: rdata_nxt = widen_ns(ns_r);
        CURRENT_SECONDS_LOW: rdata_nxt = sec_snap_r[SEC_LO_W-1:0];
        CURRENT_SECONDS_HIGH: rdata_nxt = {{(DATA_W-SEC_HI_W){1'b0}},
                                           sec_snap_r[SEC_W-1:SEC_LO_W]};
        TIMER_IRQ_CLEAR: rdata_nxt = READ_ZERO;
        OUTPUT_PHASE_OFFSET: rdata_nxt = widen_ns(phase_r);
        default: rdata_nxt = READ_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r <= READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // read data straight from its flop
  assign rdata_o = rdata_r;

  // ==========================================================================
  // derived 8 kHz timing output
  phase_square_gen phase_square_gen_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .enable_i(opt_en),
    .ns_i(ns_r),
    .phase_i(phase_r),
    .eight_khz_timing_out_o(eight_khz_timing_out_o)
  );

  // ==========================================================================
  // checks
  property p_ns_off_reserved;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_i && hit(addr_i, NANOSECOND_STEP_OFFSET))
        |=> rdata_o[DATA_W-1:NS_W] == '0 && rdata_o[NS_W-1:0] == ns_off_r;
  endproperty
  a_ns_off_reserved:
    assert property (p_ns_off_reserved) else $error("ns offset read wrong");

  property p_sec_hi_store;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && wr_i && hit(addr_i, SECOND_STEP_OFFSET_HIGH))
        |=> sec_off_hi_r == $past(wdata_i[SEC_HI_W-1:0]);
  endproperty
  a_sec_hi_store:
    assert property (p_sec_hi_store) else $error("seconds high offset not stored");

  property p_step_load;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && wr_i && hit(addr_i, NANOSECOND_STEP_OFFSET))
        |=> ns_r == $past(wdata_i[NS_W-1:0])
            && sec_r == {$past(sec_off_hi_r), $past(sec_off_lo_r)}
            && frac_r == FRAC_RST;
  endproperty
  a_step_load:
    assert property (p_step_load) else $error("offset step not applied together");

  property p_advance;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && !wr_ns_off && !sec_carry)
        |=> {ns_r, frac_r} == $past({ns_r, frac_r}) + {{(ACC_W-INC_W){1'b0}}, $past(inc_r)}
            && sec_r == $past(sec_r);
  endproperty
  a_advance:
    assert property (p_advance) else $error("counter did not advance by increment");

  property p_rollover;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && !wr_ns_off && sec_carry)
        |=> sec_r == $past(sec_r) + SEC_ONE && ns_r < NS_PER_SEC;
  endproperty
  a_rollover:
    assert property (p_rollover) else $error("seconds rollover wrong");

  property p_cur_ns_read;
    @(posedge mclk_i) disable iff (rst_i)
      rd_cur_ns |=> rdata_o == widen_ns($past(ns_r)) && sec_snap_r == $past(sec_r)
        ##1 rdata_o == READ_ZERO || $past(rd_i);
  endproperty
  a_cur_ns_read:
    assert property (p_cur_ns_read) else $error("current ns read or snapshot wrong");

  property p_sec_lo_read;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && rd_i && hit(addr_i, CURRENT_SECONDS_LOW))
        |=> rdata_o == $past(sec_snap_r[SEC_LO_W-1:0]);
  endproperty
  a_sec_lo_read:
    assert property (p_sec_lo_read) else $error("seconds low read not from snapshot");

  property p_irq_holds;
    @(posedge mclk_i) disable iff (rst_i)
      (timer_irq_o && !wr_irq_clr) |=> timer_irq_o;
  endproperty
  a_irq_holds:
    assert property (p_irq_holds) else $error("timer interrupt dropped without clear");

  property p_irq_clear;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_irq_clr && !(sec_carry && !wr_ns_off))
        |=> !timer_irq_o;
  endproperty
  a_irq_clear:
    assert property (p_irq_clear) else $error("interrupt clear write had no effect");

  property p_irq_clr_reads_zero;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_i && hit(addr_i, TIMER_IRQ_CLEAR)) |=> rdata_o == READ_ZERO;
  endproperty
  a_irq_clr_reads_zero:
    assert property (p_irq_clr_reads_zero) else $error("interrupt clear read not zero");

  property p_option_off;
    @(posedge mclk_i) disable iff (rst_i)
      !opt_en |-> rdata_o == READ_ZERO && !timer_irq_o;
  endproperty
  a_option_off:
    assert property (p_option_off) else $error("registers active without option");

  property p_sec_hi_read;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && rd_i && hit(addr_i, CURRENT_SECONDS_HIGH))
        |=> rdata_o == {{(DATA_W-SEC_HI_W){1'b0}}, $past(sec_snap_r[SEC_W-1:SEC_LO_W])};
  endproperty
  a_sec_hi_read:
    assert property (p_sec_hi_read) else $error("seconds high read not from snapshot");

  property p_snapshot_hold;
    @(posedge mclk_i) disable iff (rst_i)
      !rd_cur_ns |=> sec_snap_r == $past(sec_snap_r);
  endproperty
  a_snapshot_hold:
    assert property (p_snapshot_hold) else $error("seconds snapshot moved without ns read");

  property p_irq_set;
    @(posedge mclk_i) disable iff (rst_i)
      (opt_en && !wr_ns_off && sec_carry) |=> timer_irq_o;
  endproperty
  a_irq_set:
    assert property (p_irq_set) else $error("rollover did not raise timer interrupt");

endmodule

// file: hdl/ptp_time_pkg.sv
// ptp_time_pkg: register map, field widths and timing constants of the
// time counter used for precision time stamping.
// assumes: included by every design file of the time counter through import.
package ptp_time_pkg;

  // ==========================================================================
  // bus and field widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int NS_W = 30;
  localparam int FRAC_W = 20;
  localparam int ACC_W = NS_W + FRAC_W;
  localparam int SEC_W = 48;
  localparam int SEC_LO_W = 32;
  localparam int SEC_HI_W = 16;
  localparam int INC_W = 26;
  localparam int PHASE_W = 30;
  localparam int SUM_W = NS_W + 1;
  localparam int IRQ_CLR_BIT = 0;

  // ==========================================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] NANOSECOND_STEP_OFFSET = 32'h0001_2800;
  localparam logic [ADDR_W-1:0] SECOND_STEP_OFFSET_LOW = 32'h0001_2808;
  localparam logic [ADDR_W-1:0] SECOND_STEP_OFFSET_HIGH = 32'h0001_280C;
  localparam logic [ADDR_W-1:0] COUNT_INCREMENT = 32'h0001_2810;
  localparam logic [ADDR_W-1:0] CURRENT_NANOSECONDS = 32'h0001_2814;
  localparam logic [ADDR_W-1:0] CURRENT_SECONDS_LOW = 32'h0001_2818;
  localparam logic [ADDR_W-1:0] CURRENT_SECONDS_HIGH = 32'h0001_281C;
  localparam logic [ADDR_W-1:0] TIMER_IRQ_CLEAR = 32'h0001_2820;
  localparam logic [ADDR_W-1:0] OUTPUT_PHASE_OFFSET = 32'h0001_2824;

  // ==========================================================================
  // reset values
  localparam logic [NS_W-1:0] NS_RST = 30'h0000_0000;
  localparam logic [FRAC_W-1:0] FRAC_RST = 20'h0_0000;
  localparam logic [SEC_W-1:0] SEC_RST = 48'h0000_0000_0000;
  localparam logic [INC_W-1:0] INC_RST = 26'h000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 30'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================================
  // time constants, in nanoseconds, and the one-second step of the seconds count
  localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3B9A_CA00;
  localparam logic [SUM_W-1:0] EIGHT_KHZ_PERIOD_NS = 31'h0001_E848;
  localparam logic [SUM_W-1:0] EIGHT_KHZ_HIGH_NS = 31'h0000_F424;
  localparam logic [SEC_W-1:0] SEC_ONE = 48'h0000_0000_0001;

endpackage

// file: hdl/phase_square_gen.sv
// phase_square_gen: 8 kHz square wave derived from the nanoseconds count
// plus a phase offset.
// assumes: ns_i and phase_i are synchronous to mclk_i.
`timescale 1ns/1ps
module phase_square_gen
  import ptp_time_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [NS_W-1:0] ns_i,
  input wire logic [PHASE_W-1:0] phase_i,
  output logic eight_khz_timing_out_o
);

  // ==========================================================================
  // phase folding
  // one second is a whole number of 8 kHz periods, so the sum may be folded
  // by the period directly without first wrapping at one second
  function automatic logic [SUM_W-1:0] fold_period(input logic [SUM_W-1:0] v);
    fold_period = v % EIGHT_KHZ_PERIOD_NS;
  endfunction

  logic [SUM_W-1:0] phase_sum;
  logic [SUM_W-1:0] phase_fold;
  logic wave_nxt;

  // phase-shifted time with 1 ns resolution
  always_comb begin
    phase_sum = {1'b0, ns_i} + {1'b0, phase_i};
    phase_fold = fold_period(phase_sum);
    wave_nxt = enable_i && (phase_fold < EIGHT_KHZ_HIGH_NS);
  end

  // registered output wave
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eight_khz_timing_out_o <= 1'b0;
    end else begin
      eight_khz_timing_out_o <= wave_nxt;
    end
  end

  // ==========================================================================
  // checks
  property p_wave_phase;
    @(posedge mclk_i) disable iff (rst_i)
      enable_i |=> eight_khz_timing_out_o ==
        ((({1'b0, $past(ns_i)} + {1'b0, $past(phase_i)}) % EIGHT_KHZ_PERIOD_NS)
         < EIGHT_KHZ_HIGH_NS);
  endproperty
  a_wave_phase:
    assert property (p_wave_phase) else $error("8 kHz wave not set by phase sum");

  property p_wave_shift;
    @(posedge mclk_i) disable iff (rst_i)
      (enable_i && phase_i == PHASE_RST && ns_i == NS_RST)
        |=> eight_khz_timing_out_o;
  endproperty
  a_wave_shift:
    assert property (p_wave_shift) else $error("8 kHz wave low at period start");

endmodule

// file: dv/tb_ptp_time_counter_regs.sv
// tb_ptp_time_counter_regs: self-checking bench for the time counter register set.
// assumes: ptp_time_pkg and the design files are compiled before this file.
`timescale 1ns/1ps
module tb_ptp_time_counter_regs;
  import ptp_time_pkg::*;

  // ==========================================================================
  // signals
  logic mclk_i;
  logic rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic timer_irq_o;
  logic eight_khz_timing_out_o;
  logic [DATA_W-1:0] off_rdata;
  logic off_irq;
  logic off_wave;
  int mismatches;
  int samples_checked;

  // ==========================================================================
  // instances: option built in, and option left out
  ptp_time_counter_regs #(.audio_video_bridging_option(1'b1)) ptp_time_counter_regs_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .timer_irq_o(timer_irq_o),
    .eight_khz_timing_out_o(eight_khz_timing_out_o)
  );

  ptp_time_counter_regs #(.audio_video_bridging_option(1'b0)) ptp_time_counter_regs_off_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(off_rdata),
    .timer_irq_o(off_irq),
    .eight_khz_timing_out_o(off_wave)
  );

  // ==========================================================================
  // clock, 10 ns period
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // comparison, bus tasks and verdict
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data is taken only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    check(rdata_o, exp);
    check(off_rdata, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // seconds parts first, nanoseconds last
  task automatic step(input logic [DATA_W-1:0] ns, input logic [DATA_W-1:0] lo,
                      input logic [DATA_W-1:0] hi);
    wr(SECOND_STEP_OFFSET_LOW, lo);
    wr(SECOND_STEP_OFFSET_HIGH, hi);
    wr(NANOSECOND_STEP_OFFSET, ns);
  endtask

  // counter moves by inc on n + 2 edges, then stops
  task automatic run(input logic [DATA_W-1:0] inc, input int n);
    wr(COUNT_INCREMENT, inc);
    idle(n);
    wr(COUNT_INCREMENT, 32'h0000_0000);
  endtask

  task automatic time3(input logic [DATA_W-1:0] ns, input logic [DATA_W-1:0] lo,
                       input logic [DATA_W-1:0] hi);
    rd_chk(CURRENT_NANOSECONDS, ns);
    rd_chk(CURRENT_SECONDS_LOW, lo);
    rd_chk(CURRENT_SECONDS_HIGH, hi);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge mclk_i);
    check({31'h0000_0000, timer_irq_o}, {31'h0000_0000, e});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [DATA_W-1:0] wns [7];
    logic [DATA_W-1:0] wph [7];
    logic e;
    wns = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0001_E847, 32'h0000_F423, 32'h0000_F424};
    wph = '{32'h0, 32'h0000_F424, 32'h0000_F423, 32'h0000_F423, 32'h1, 32'h0, 32'h0};
    rst_i = 1'b1;
    addr_i = 32'h0000_0000;
    wdata_i = 32'h0000_0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    // reset values of the whole map, reserved slot included
    for (int i = 0; i < 10; i++) begin
      rd_chk(NANOSECOND_STEP_OFFSET + 32'(4 * i), 32'h0000_0000);
    end
    irq_chk(1'b0);
    // read back with reserved bits, reserved address, read-only targets
    wr(SECOND_STEP_OFFSET_LOW, 32'hFFFF_FFFF);
    wr(SECOND_STEP_OFFSET_HIGH, 32'hFFFF_FFFF);
    wr(OUTPUT_PHASE_OFFSET, 32'hFFFF_FFFF);
    wr(32'h0001_2804, 32'hFFFF_FFFF);
    wr(NANOSECOND_STEP_OFFSET, 32'hC000_03E7);
    wr(CURRENT_NANOSECONDS, 32'hFFFF_FFFF);
    rd_chk(NANOSECOND_STEP_OFFSET, 32'h0000_03E7);
    rd_chk(SECOND_STEP_OFFSET_LOW, 32'hFFFF_FFFF);
    rd_chk(SECOND_STEP_OFFSET_HIGH, 32'h0000_FFFF);
    rd_chk(OUTPUT_PHASE_OFFSET, 32'h3FFF_FFFF);
    rd_chk(32'h0001_2804, 32'h0000_0000);
    time3(32'h0000_03E7, 32'hFFFF_FFFF, 32'h0000_FFFF);
    wr(COUNT_INCREMENT, 32'hFFFF_FFFF);
    rd_chk(COUNT_INCREMENT, 32'h03FF_FFFF);
    wr(COUNT_INCREMENT, 32'h0000_0000);
    wr(TIMER_IRQ_CLEAR, 32'h0000_0000);
    rd_chk(TIMER_IRQ_CLEAR, 32'h0000_0000);
    // step load, then fractional advance of half and quarter nanoseconds
    step(32'h0000_0064, 32'h89AB_CDEF, 32'h0000_5678);
    time3(32'h0000_0064, 32'h89AB_CDEF, 32'h0000_5678);
    run(32'h0008_0000, 0);
    rd_chk(CURRENT_NANOSECONDS, 32'h0000_0065);
    run(32'h0004_0000, 0);
    rd_chk(CURRENT_NANOSECONDS, 32'h0000_0065);
    run(32'h0004_0000, 0);
    rd_chk(CURRENT_NANOSECONDS, 32'h0000_0066);
    // new step without a nanoseconds read keeps the old seconds snapshot
    step(32'h3B9A_C9D8, 32'hFFFF_FFFF, 32'h0000_1234);
    rd_chk(CURRENT_SECONDS_LOW, 32'h89AB_CDEF);
    rd_chk(CURRENT_SECONDS_HIGH, 32'h0000_5678);
    irq_chk(1'b0);
    // six steps of 10 ns cross one second with a carry into the high part
    run(32'h00A0_0000, 4);
    time3(32'h0000_0014, 32'h0000_0000, 32'h0000_1235);
    irq_chk(1'b1);
    idle(8);
    irq_chk(1'b1);
    wr(TIMER_IRQ_CLEAR, 32'h0000_0000);
    idle(1);
    irq_chk(1'b0);
    // square wave from count plus phase
    for (int i = 0; i < 7; i++) begin
      wr(OUTPUT_PHASE_OFFSET, wph[i]);
      step(wns[i], 32'h0000_0000, 32'h0000_0000);
      idle(3);
      @(negedge mclk_i);
      e = ((wns[i] + wph[i]) % EIGHT_KHZ_PERIOD_NS) < EIGHT_KHZ_HIGH_NS;
      check({31'h0, eight_khz_timing_out_o}, {31'h0, e});
    end
    check({30'h0, off_irq, off_wave}, 32'h0000_0000);
    results();
  end

endmodule
